/* File: include/radio_cfg_pkg.sv */
// Package for the radio common configuration register bank.
// Assumes a 50 MHz clock; shared by the bank and its phase timer.
package radio_cfg_pkg;

  // Register addresses on the host register port
  localparam logic [7:0] ADDR_OP_MODE = 8'h01;
  localparam logic [7:0] ADDR_RATE_HIGH = 8'h03;
  localparam logic [7:0] ADDR_RATE_LOW = 8'h04;
  localparam logic [7:0] ADDR_DEV_HIGH = 8'h05;
  localparam logic [7:0] ADDR_DEV_LOW = 8'h06;
  localparam logic [7:0] ADDR_FREQ_HIGH = 8'h07;
  localparam logic [7:0] ADDR_FREQ_MID = 8'h08;
  localparam logic [7:0] ADDR_FREQ_LOW = 8'h09;
  localparam logic [7:0] ADDR_RC_OSC = 8'h0a;
  localparam logic [7:0] ADDR_AFC_CTRL = 8'h0b;
  localparam logic [7:0] ADDR_BATTERY = 8'h0c;
  localparam logic [7:0] ADDR_LISTEN_CFG = 8'h0d;
  localparam logic [7:0] ADDR_IDLE_COEFF = 8'h0e;
  localparam logic [7:0] ADDR_RX_COEFF = 8'h0f;
  localparam logic [7:0] ADDR_VERSION = 8'h10;

  // Values after reset
  localparam logic [7:0] RST_RATE_HIGH = 8'h1a;
  localparam logic [7:0] RST_RATE_LOW = 8'h0b;
  localparam logic [5:0] RST_DEV_HIGH = 6'h00;
  localparam logic [7:0] RST_DEV_LOW = 8'h52;
  localparam logic [7:0] RST_FREQ_HIGH = 8'he4;
  localparam logic [7:0] RST_FREQ_MID = 8'hc0;
  localparam logic [7:0] RST_FREQ_LOW = 8'h00;
  localparam logic [2:0] RST_TRIM = 3'h2;
  localparam logic [1:0] RST_IDLE_UNIT = 2'h2;
  localparam logic [1:0] RST_RX_UNIT = 2'h1;
  localparam logic [1:0] RST_END_ACTION = 2'h1;
  localparam logic [7:0] RST_IDLE_COEFF = 8'hf5;
  localparam logic [7:0] RST_RX_COEFF = 8'h20;
  localparam logic [5:0] OSC_UNUSED_BITS = 6'h01;

  // Field positions
  localparam int BIT_SEQ_OFF = 7;
  localparam int BIT_LISTEN_ON = 6;
  localparam int BIT_LISTEN_ABORT = 5;
  localparam int BIT_CAL_TRIGGER = 7;
  localparam int BIT_LOW_INDEX_AFC = 5;
  localparam int BIT_BAT_ENABLE = 3;

  // Operating modes and post-accept actions
  localparam logic [2:0] MODE_SLEEP = 3'h0;
  localparam logic [2:0] MODE_STANDBY = 3'h1;
  localparam logic [2:0] MODE_RX = 3'h4;
  localparam logic [1:0] END_STAY_RX = 2'h0;
  localparam logic [1:0] END_GO_MODE = 2'h1;
  localparam logic [1:0] END_RESUME = 2'h2;

  // Timing at a 20 ns clock
  localparam int CLOCK_PERIOD_NS = 20;
  localparam int UNIT_SHORT_NS = 64000;
  localparam int UNIT_MID_NS = 4100000;
  localparam int UNIT_LONG_NS = 262000000;
  localparam int RC_CAL_TIME_NS = 20000;
  localparam int UNIT_SHORT_CYCLES = UNIT_SHORT_NS / CLOCK_PERIOD_NS;
  localparam int UNIT_MID_CYCLES = UNIT_MID_NS / CLOCK_PERIOD_NS;
  localparam int UNIT_LONG_CYCLES = UNIT_LONG_NS / CLOCK_PERIOD_NS;
  localparam int RC_CAL_CYCLES = RC_CAL_TIME_NS / CLOCK_PERIOD_NS;

  // Listen duty-cycle sequencer states
  typedef enum logic [4:0] {
    LS_OFF = 5'h01,
    LS_IDLE = 5'h02,
    LS_RX = 5'h04,
    LS_HOLD = 5'h08,
    LS_STOP = 5'h10
  } listen_state_e;

  // Configuration words driven to the radio
  typedef struct packed {
    logic [15:0] rate_divisor;
    logic [13:0] deviation;
    logic [23:0] carrier_word;
    logic low_index_afc_select;
    logic battery_detector_enable;
    logic [2:0] battery_threshold_trim;
  } radio_config_s;

  // Listen mode settings
  typedef struct packed {
    logic [1:0] idle_time_unit;
    logic [1:0] rx_time_unit;
    logic accept_criterion;
    logic [1:0] post_accept_action;
    logic [7:0] idle_time_coeff;
    logic [7:0] rx_time_coeff;
  } listen_config_s;

  // Events reported by the modem and analog side
  typedef struct packed {
    logic signal_strength_limit;
    logic sync_and_address_match;
    logic payload_complete_flag;
    logic rx_timeout;
    logic battery_comparator;
  } radio_events_s;

endpackage : radio_cfg_pkg

/* File: rtl/phase_timer.sv */
// Listen phase timer: counts coeff times the selected time unit.
// Assumes start is a one-cycle pulse; unit lengths come as parameters.
`timescale 1ns/1ps
module phase_timer
  import radio_cfg_pkg::*;
#(
  parameter int unsigned SHORT_CYCLES = UNIT_SHORT_CYCLES,
  parameter int unsigned MID_CYCLES = UNIT_MID_CYCLES,
  parameter int unsigned LONG_CYCLES = UNIT_LONG_CYCLES
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [1:0] unit,
  input wire logic [7:0] coeff,
  output logic expired
);

  typedef struct packed {
    logic [23:0] unit_count;
    logic [7:0] coeff_count;
    logic running;
    logic expired;
  } timer_s;

  timer_s s;
  timer_s next_s;

  // Unit length in cycles; reserved code falls back to the short unit
  function automatic logic [23:0] unit_len(input logic [1:0] code);
    unique case (code)
      2'h2: unit_len = 24'(MID_CYCLES);
      2'h3: unit_len = 24'(LONG_CYCLES);
      default: unit_len = 24'(SHORT_CYCLES);
    endcase
  endfunction : unit_len

  // Two nested down counters, units inside coefficient
  always_comb begin
    next_s = s;
    next_s.expired = 1'b0;
    if (start) begin
      next_s.coeff_count = coeff;
      next_s.unit_count = unit_len(unit) - 24'h0001;
      next_s.running = (coeff != 8'h00);
      next_s.expired = (coeff == 8'h00);
    end else if (s.running) begin
      if (s.unit_count != 24'h0000) begin
        next_s.unit_count = s.unit_count - 24'h0001;
      end else if (s.coeff_count == 8'h01) begin
        next_s.running = 1'b0;
        next_s.expired = 1'b1;
      end else begin
        next_s.coeff_count = s.coeff_count - 8'h01;
        next_s.unit_count = unit_len(unit) - 24'h0001;
      end
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign expired = s.expired;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  chk_zero_coeff_fast: assert property ( // RULE17
    start && coeff == 8'h00 |=> expired)
    else $error("Zero coefficient did not expire at once");

endmodule : phase_timer

/* File: rtl/radio_config_regs.sv */
// Summary of operation
// RULE1 - Low divisor byte sets bit rate
// RULE2 - Deviation is fourteen bits over two registers
// RULE3 - Carrier word formed from three bytes
// RULE4 - Trigger bit starts RC calibration, reads zero
// RULE5 - Host calibrates only from standby mode; the bank accepts the trigger in any mode
// RULE6 - Done bit low while calibrating, else high
// RULE7 - AFC bit selects low index routine
// RULE8 - Live battery flag while detector enabled
// RULE9 - Enable bit switches battery detector, reset off
// RULE10 - Trim code picks one of eight thresholds
// RULE11 - Idle unit code selects phase time unit
// RULE12 - Receive unit uses same encoding, reset 01
// RULE13 - Acceptance needs signal level, optionally sync
// RULE14 - Action 00 stays receiving, host disables
// RULE15 - Action 01 waits, then enters chosen mode
// RULE16 - Action 10 waits, resumes idle, discards FIFO
// RULE17 - Idle phase equals coefficient times unit
// RULE18 - Receive phase equals coefficient times unit
// RULE19 - Read-only version code register
// RULE20 - Mode field encodes modes, reads current
// RULE21 - High divisor byte just below, reset 1a
// RULE22 - Listen enable starts, abort stops listening
// RULE23 - Unused bits constant, triggers read zero
// RULE24 - Registers load reset values, hold writes
//
// Register bank with listen duty-cycle sequencer.
// Assumes one-cycle strobes, never both at once; read data next cycle.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module radio_config_regs
  import radio_cfg_pkg::*;
#(
  parameter logic [7:0] VERSION_CODE = 8'h11, // Arbitrary value
  parameter int unsigned MID_UNIT_CYCLES = UNIT_MID_CYCLES,
  parameter int unsigned LONG_UNIT_CYCLES = UNIT_LONG_CYCLES
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [7:0] address,
  input wire logic [7:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  output logic [7:0] read_data,
  input wire radio_events_s radio_events,
  output radio_config_s radio_config,
  output logic [2:0] chip_mode,
  output logic sequencer_forced,
  output logic rc_cal_finished,
  output logic battery_low_live,
  output logic listen_active,
  output logic fifo_discard
);

  typedef struct packed {
    radio_config_s cfg;
    listen_config_s lcfg;
    logic [2:0] mode_sel;
    logic seq_off;
    logic listen_enable;
    listen_state_e ls;
    logic stop_in_rx;
    logic [2:0] chip_mode;
    logic cal_done;
    logic [15:0] cal_count;
    logic live;
    logic flush_pending;
    logic fifo_discard;
    logic listening;
    logic timer_start;
    logic [1:0] timer_unit;
    logic [7:0] timer_coeff;
    logic [7:0] read_data;
  } state_s;

  localparam state_s STATE_RESET = '{
    cfg: '{
      rate_divisor: {RST_RATE_HIGH, RST_RATE_LOW},
      deviation: {RST_DEV_HIGH, RST_DEV_LOW},
      carrier_word: {RST_FREQ_HIGH, RST_FREQ_MID, RST_FREQ_LOW},
      low_index_afc_select: 1'b0,
      battery_detector_enable: 1'b0,
      battery_threshold_trim: RST_TRIM
    },
    lcfg: '{
      idle_time_unit: RST_IDLE_UNIT,
      rx_time_unit: RST_RX_UNIT,
      accept_criterion: 1'b0,
      post_accept_action: RST_END_ACTION,
      idle_time_coeff: RST_IDLE_COEFF,
      rx_time_coeff: RST_RX_COEFF
    },
    mode_sel: MODE_STANDBY,
    seq_off: 1'b0,
    listen_enable: 1'b0,
    ls: LS_OFF,
    stop_in_rx: 1'b0,
    chip_mode: MODE_STANDBY,
    cal_done: 1'b1,
    cal_count: 16'h0000,
    live: 1'b0,
    flush_pending: 1'b0,
    fifo_discard: 1'b0,
    listening: 1'b0,
    timer_start: 1'b0,
    timer_unit: 2'h0,
    timer_coeff: 8'h00,
    read_data: 8'h00
  };

  state_s s;
  state_s next_s;
  logic timer_expired;
  logic wr_op;
  logic abort;
  logic accept;
  logic rx_over;

  // Phase timer for idle and receive windows
  phase_timer #(
    .SHORT_CYCLES(UNIT_SHORT_CYCLES),
    .MID_CYCLES(MID_UNIT_CYCLES),
    .LONG_CYCLES(LONG_UNIT_CYCLES)
  ) u_phase_timer (
    .clock(clock),
    .rst_b(rst_b),
    .start(s.timer_start),
    .unit(s.timer_unit),
    .coeff(s.timer_coeff),
    .expired(timer_expired)
  );

  // Read view of every register
  function automatic logic [7:0] reg_value(input logic [7:0] addr,
                                           input state_s st);
    unique case (addr)
      ADDR_OP_MODE: reg_value = {st.seq_off, st.listen_enable, 1'b0,
                                 st.chip_mode, 2'b00}; // RULE20 RULE22
      ADDR_RATE_HIGH: reg_value = st.cfg.rate_divisor[15:8]; // RULE21
      ADDR_RATE_LOW: reg_value = st.cfg.rate_divisor[7:0]; // RULE1
      ADDR_DEV_HIGH: reg_value = {2'b00, st.cfg.deviation[13:8]}; // RULE2
      ADDR_DEV_LOW: reg_value = st.cfg.deviation[7:0];
      ADDR_FREQ_HIGH: reg_value = st.cfg.carrier_word[23:16]; // RULE3
      ADDR_FREQ_MID: reg_value = st.cfg.carrier_word[15:8];
      ADDR_FREQ_LOW: reg_value = st.cfg.carrier_word[7:0];
      ADDR_RC_OSC: reg_value = {1'b0, st.cal_done,
                                OSC_UNUSED_BITS}; // RULE4 RULE6 RULE23
      ADDR_AFC_CTRL: reg_value = {2'b00, st.cfg.low_index_afc_select,
                                  5'h00};
      ADDR_BATTERY: reg_value = {3'h0, st.live,
                                 st.cfg.battery_detector_enable,
                                 st.cfg.battery_threshold_trim}; // RULE8
      ADDR_LISTEN_CFG: reg_value = {st.lcfg.idle_time_unit,
                                    st.lcfg.rx_time_unit,
                                    st.lcfg.accept_criterion,
                                    st.lcfg.post_accept_action, 1'b0};
      ADDR_IDLE_COEFF: reg_value = st.lcfg.idle_time_coeff;
      ADDR_RX_COEFF: reg_value = st.lcfg.rx_time_coeff;
      ADDR_VERSION: reg_value = VERSION_CODE; // RULE19
      default: reg_value = 8'h00;
    endcase
  endfunction : reg_value

  // Decoded events of this cycle
  assign wr_op = write_strobe && address == ADDR_OP_MODE;
  assign abort = wr_op && write_data[BIT_LISTEN_ABORT]
                 && !write_data[BIT_LISTEN_ON]; // RULE22
  assign accept = radio_events.signal_strength_limit
                  && (!s.lcfg.accept_criterion
                      || radio_events.sync_and_address_match); // RULE13
  assign rx_over = radio_events.payload_complete_flag
                   || radio_events.rx_timeout;

  // Next state: register writes, calibration, battery, listen
  always_comb begin
    next_s = s;
    next_s.timer_start = 1'b0;
    next_s.fifo_discard = 1'b0;
    next_s.read_data = read_strobe ? reg_value(address, s) : 8'h00;

    // RC calibration countdown; a trigger written below restarts it
    if (!s.cal_done) begin // RULE6
      if (s.cal_count == 16'h0000) begin
        next_s.cal_done = 1'b1;
      end else begin
        next_s.cal_count = s.cal_count - 16'h0001;
      end
    end

    // Register writes; unused bits never stored
    if (write_strobe) begin // RULE23 RULE24
      unique case (address)
        ADDR_OP_MODE: begin
          next_s.seq_off = write_data[BIT_SEQ_OFF];
          next_s.listen_enable = write_data[BIT_LISTEN_ON]; // RULE22
          next_s.mode_sel = write_data[4:2]; // RULE20
        end
        ADDR_RATE_HIGH: next_s.cfg.rate_divisor[15:8] = write_data; // RULE21
        ADDR_RATE_LOW: next_s.cfg.rate_divisor[7:0] = write_data; // RULE1
        ADDR_DEV_HIGH: next_s.cfg.deviation[13:8] = write_data[5:0]; // RULE2
        ADDR_DEV_LOW: next_s.cfg.deviation[7:0] = write_data; // RULE2
        ADDR_FREQ_HIGH: next_s.cfg.carrier_word[23:16] = write_data; // RULE3
        ADDR_FREQ_MID: next_s.cfg.carrier_word[15:8] = write_data; // RULE3
        ADDR_FREQ_LOW: next_s.cfg.carrier_word[7:0] = write_data; // RULE3
        ADDR_RC_OSC: begin
          if (write_data[BIT_CAL_TRIGGER]) begin // RULE4
            next_s.cal_done = 1'b0;
            next_s.cal_count = 16'(RC_CAL_CYCLES - 1);
          end
        end
        ADDR_AFC_CTRL: begin
          next_s.cfg.low_index_afc_select =
            write_data[BIT_LOW_INDEX_AFC]; // RULE7
        end
        ADDR_BATTERY: begin
          next_s.cfg.battery_detector_enable =
            write_data[BIT_BAT_ENABLE]; // RULE9
          next_s.cfg.battery_threshold_trim = write_data[2:0]; // RULE10
        end
        ADDR_LISTEN_CFG: begin
          next_s.lcfg.idle_time_unit = write_data[7:6]; // RULE11
          next_s.lcfg.rx_time_unit = write_data[5:4]; // RULE12
          next_s.lcfg.accept_criterion = write_data[3]; // RULE13
          next_s.lcfg.post_accept_action = write_data[2:1];
        end
        ADDR_IDLE_COEFF: next_s.lcfg.idle_time_coeff = write_data;
        ADDR_RX_COEFF: next_s.lcfg.rx_time_coeff = write_data;
        default: ;
      endcase
    end

    // Live comparator view, forced low while the detector is off
    next_s.live = s.cfg.battery_detector_enable
                  && radio_events.battery_comparator; // RULE8

    // Listen duty-cycle sequencer
    unique case (s.ls)
      LS_OFF: begin
        if (s.listen_enable) begin // RULE22
          next_s.ls = LS_IDLE;
          next_s.timer_start = 1'b1;
          next_s.timer_unit = s.lcfg.idle_time_unit;
          next_s.timer_coeff = s.lcfg.idle_time_coeff; // RULE17
        end
      end
      LS_IDLE: begin
        if (timer_expired) begin
          next_s.ls = LS_RX;
          next_s.timer_start = 1'b1;
          next_s.timer_unit = s.lcfg.rx_time_unit;
          next_s.timer_coeff = s.lcfg.rx_time_coeff; // RULE18
          next_s.fifo_discard = s.flush_pending; // RULE16
          next_s.flush_pending = 1'b0;
        end
      end
      LS_RX: begin
        if (accept) begin
          if (s.lcfg.post_accept_action == END_STAY_RX) begin // RULE14
            next_s.ls = LS_STOP;
            next_s.stop_in_rx = 1'b1;
          end else begin
            next_s.ls = LS_HOLD;
          end
        end else if (timer_expired) begin
          next_s.ls = LS_IDLE;
          next_s.timer_start = 1'b1;
          next_s.timer_unit = s.lcfg.idle_time_unit;
          next_s.timer_coeff = s.lcfg.idle_time_coeff; // RULE17
        end
      end
      LS_HOLD: begin
        if (rx_over) begin
          if (s.lcfg.post_accept_action == END_RESUME) begin // RULE16
            next_s.ls = LS_IDLE;
            next_s.flush_pending = 1'b1;
            next_s.timer_start = 1'b1;
            next_s.timer_unit = s.lcfg.idle_time_unit;
            next_s.timer_coeff = s.lcfg.idle_time_coeff;
          end else begin // RULE15
            next_s.ls = LS_STOP;
            next_s.stop_in_rx = 1'b0;
          end
        end
      end
      LS_STOP: begin
        if (!s.listen_enable) begin // RULE14
          next_s.ls = LS_OFF;
        end
      end
    endcase

    // Abort wins over any sequencer step
    if (abort) begin // RULE22
      next_s.ls = LS_OFF;
      next_s.flush_pending = 1'b0;
    end

    // Reported chip mode follows the sequencer
    unique case (next_s.ls)
      LS_IDLE: next_s.chip_mode = MODE_SLEEP;
      LS_RX, LS_HOLD: next_s.chip_mode = MODE_RX;
      LS_STOP: begin
        next_s.chip_mode = next_s.stop_in_rx ? MODE_RX
                                             : next_s.mode_sel; // RULE15
      end
      default: next_s.chip_mode = next_s.mode_sel; // RULE20
    endcase
    next_s.listening = (next_s.ls != LS_OFF);
  end

  // State register
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s <= STATE_RESET; // RULE24
    end else begin
      s <= next_s;
    end
  end

  // Outputs, each straight from the state register
  assign read_data = s.read_data;
  assign radio_config = s.cfg;
  assign chip_mode = s.chip_mode;
  assign sequencer_forced = s.seq_off;
  assign rc_cal_finished = s.cal_done;
  assign battery_low_live = s.live;
  assign listen_active = s.listening;
  assign fifo_discard = s.fifo_discard;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence resume_event;
    s.ls == LS_HOLD && s.lcfg.post_accept_action == END_RESUME && rx_over
    && !abort;
  endsequence

  sequence resume_outcome;
    s.ls == LS_IDLE && s.flush_pending;
  endsequence

  chk_reset_values: assert property ( // RULE24
    $rose(rst_b) |-> radio_config.rate_divisor == 16'h1a0b
      && radio_config.carrier_word == 24'he4_c000
      && rc_cal_finished && chip_mode == MODE_STANDBY)
    else $error("Registers left reset with wrong values");

  chk_cal_running: assert property ( // RULE6
    write_strobe && address == ADDR_RC_OSC && write_data[7]
    |=> !rc_cal_finished [*8])
    else $error("Calibration done flag did not drop");

  chk_trigger_zero: assert property ( // RULE4
    read_strobe && address == ADDR_RC_OSC |=> !read_data[7])
    else $error("Calibration trigger read back as one");

  chk_abort_zero: assert property ( // RULE22
    read_strobe && address == ADDR_OP_MODE |=> !read_data[5])
    else $error("Abort bit read back as one");

  chk_battery_live: assert property ( // RULE8
    ##1 1'b1 |-> battery_low_live
      == $past(s.cfg.battery_detector_enable
               && radio_events.battery_comparator))
    else $error("Battery flag not following detector");

  chk_afc_select: assert property ( // RULE7
    write_strobe && address == ADDR_AFC_CTRL
    |=> radio_config.low_index_afc_select == $past(write_data[5]))
    else $error("AFC routine select not written");

  chk_stay_rx: assert property ( // RULE14
    s.ls == LS_RX && accept && !abort
    && s.lcfg.post_accept_action == END_STAY_RX
    |=> s.ls == LS_STOP && chip_mode == MODE_RX)
    else $error("Accepted packet did not hold receive");

  chk_sync_needed: assert property ( // RULE13
    s.ls == LS_RX && s.lcfg.accept_criterion
    && !radio_events.sync_and_address_match && !timer_expired && !abort
    |=> s.ls == LS_RX)
    else $error("Packet accepted without sync match");

  chk_go_mode: assert property ( // RULE15
    s.ls == LS_HOLD && s.lcfg.post_accept_action == END_GO_MODE
    && rx_over && !abort && !write_strobe
    |=> s.ls == LS_STOP && chip_mode == s.mode_sel)
    else $error("Did not enter selected mode after receive");

  chk_resume_idle: assert property ( // RULE16
    resume_event |=> resume_outcome)
    else $error("Listening did not resume in idle");

  chk_version_read: assert property ( // RULE19
    read_strobe && address == ADDR_VERSION |=> read_data == VERSION_CODE)
    else $error("Version code read wrong");

endmodule : radio_config_regs

/* File: bench/tb.sv */
// Self-checking bench for the radio configuration register bank.
// Drives host port and radio events itself; assertions live in the design.
`timescale 1ns/1ps
module tb;
  import radio_cfg_pkg::*;
  localparam logic [7:0] VER = 8'h5a; // Arbitrary value
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] address = 8'h00;
  logic [7:0] write_data = 8'h00;
  logic write_strobe = 1'b0;
  logic read_strobe = 1'b0;
  logic [7:0] read_data;
  radio_events_s radio_events = '0;
  radio_config_s radio_config;
  logic [2:0] chip_mode;
  logic sequencer_forced, rc_cal_finished, battery_low_live;
  logic listen_active, fifo_discard;
  int err_count = 0;
  int check_count = 0;
  logic [31:0] seed = 32'h0000_7054;
  logic [7:0] shadow [32];
  logic [7:0] v, a8, d, m;
  int n;
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
  err_count++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
  // Clock at 50 MHz
  always #10 clock = ~clock;
  radio_config_regs #(.VERSION_CODE(VER), .MID_UNIT_CYCLES(10),
    .LONG_UNIT_CYCLES(20)) DUT (.clock(clock), .rst_b(rst_b),
    .address(address), .write_data(write_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe),
    .read_data(read_data), .radio_events(radio_events),
    .radio_config(radio_config), .chip_mode(chip_mode),
    .sequencer_forced(sequencer_forced),
    .rc_cal_finished(rc_cal_finished),
    .battery_low_live(battery_low_live),
    .listen_active(listen_active), .fifo_discard(fifo_discard));
  task automatic final_report;
    if (err_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  // Value each address shows after reset
  function automatic logic [7:0] rst_val(input logic [7:0] a);
    case (a)
      ADDR_OP_MODE: return 8'h04;
      ADDR_RATE_HIGH: return RST_RATE_HIGH;
      ADDR_RATE_LOW: return RST_RATE_LOW;
      ADDR_DEV_LOW: return RST_DEV_LOW;
      ADDR_FREQ_HIGH: return RST_FREQ_HIGH;
      ADDR_FREQ_MID: return RST_FREQ_MID;
      ADDR_RC_OSC: return 8'h41;
      ADDR_BATTERY: return {5'h00, RST_TRIM};
      ADDR_LISTEN_CFG: return {RST_IDLE_UNIT, RST_RX_UNIT, 1'b0,
        RST_END_ACTION, 1'b0};
      ADDR_IDLE_COEFF: return RST_IDLE_COEFF;
      ADDR_RX_COEFF: return RST_RX_COEFF;
      ADDR_VERSION: return VER;
      default: return 8'h00;
    endcase
  endfunction : rst_val
  // Writable bits of each address
  function automatic logic [7:0] mask_of(input logic [7:0] a);
    case (a)
      ADDR_DEV_HIGH: return 8'h3f;
      ADDR_AFC_CTRL: return 8'h20;
      ADDR_BATTERY: return 8'h0f;
      ADDR_LISTEN_CFG: return 8'hfe;
      ADDR_VERSION: return 8'h00;
      default: return 8'hff;
    endcase
  endfunction : mask_of
  function automatic logic near(input int c, input int e);
    return c + 2 >= e && c <= e + 4;
  endfunction : near
  task automatic wr(input logic [7:0] a, input logic [7:0] dt);
    @(posedge clock);
    address <= a;
    write_data <= dt;
    write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] dt);
    @(posedge clock);
    address <= a;
    read_strobe <= 1'b1;
    @(posedge clock);
    read_strobe <= 1'b0;
    #1 dt = read_data;
  endtask : rd
  // Bounded wait for a chip mode, counting cycles
  task automatic wait_mode(input logic [2:0] md, output int c);
    c = 0;
    #1;
    while (chip_mode !== md) begin
      @(posedge clock);
      #1 c++;
      if (c > 400) begin
        `CHK(c, 0)
        final_report();
      end
    end
  endtask : wait_mode
  // One-cycle end-of-receive event; all other events drop as it rises and stay cleared after it
  task automatic pulse_end(input radio_events_s ev);
    radio_events <= ev;
    @(posedge clock);
    radio_events <= '0;
  endtask : pulse_end
  // Main sequence
  initial begin
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    #1;
    `CHK({chip_mode, rc_cal_finished, listen_active}, 5'h06)
    for (int a = 0; a < 20; a++) begin
      rd(a[7:0], v);
      shadow[a] = rst_val(a[7:0]);
      `CHK(v, shadow[a])
    end
    for (int i = 0; i < 80; i++) begin
      a8 = 8'h03 + (rnd() % 8'd13);
      if (a8 == ADDR_RC_OSC) a8 = ADDR_VERSION;
      d = (i < 4) ? {8{i[0]}} : rnd();
      m = mask_of(a8);
      wr(a8, d);
      shadow[a8] = (d & m) | (shadow[a8] & ~m);
      rd(a8, v);
      `CHK(v, shadow[a8])
    end
    `CHK(radio_config.rate_divisor, {shadow[3], shadow[4]})
    `CHK(radio_config.deviation, {shadow[5][5:0], shadow[6]})
    `CHK(radio_config.carrier_word, {shadow[7], shadow[8], shadow[9]})
    `CHK(radio_config.low_index_afc_select, shadow[11][5])
    `CHK(radio_config.battery_detector_enable, shadow[12][3])
    `CHK(radio_config.battery_threshold_trim, shadow[12][2:0])
    // Battery detector live flag and enable
    wr(ADDR_BATTERY, 8'h08);
    radio_events.battery_comparator <= 1'b1;
    rd(ADDR_BATTERY, v);
    `CHK(v, 8'h18)
    `CHK(battery_low_live, 1'b1)
    wr(ADDR_BATTERY, 8'h07);
    rd(ADDR_BATTERY, v);
    `CHK({v, battery_low_live}, 9'h00e)
    // Calibration from standby, trigger reads zero
    wr(ADDR_RC_OSC, 8'h80);
    rd(ADDR_RC_OSC, v);
    `CHK(v, 8'h01)
    n = 0;
    while (rc_cal_finished !== 1'b1 && n < 1100) begin
      @(posedge clock);
      #1 n++;
    end
    `CHK(near(n + 2, RC_CAL_CYCLES), 1'b1)
    // Forced sequencer bit
    wr(ADDR_OP_MODE, 8'h84);
    rd(ADDR_OP_MODE, v);
    `CHK({v, sequencer_forced}, 9'h109)
    // Action 10: timeout without sync, then accept and resume
    wr(ADDR_IDLE_COEFF, 8'h02);
    wr(ADDR_RX_COEFF, 8'h03);
    wr(ADDR_LISTEN_CFG, 8'hac);
    wr(ADDR_OP_MODE, 8'h44);
    wait_mode(MODE_RX, n);
    `CHK(near(n, 20), 1'b1)
    @(posedge clock);
    radio_events.signal_strength_limit <= 1'b1;
    wait_mode(MODE_SLEEP, n);
    `CHK(near(n, 30), 1'b1)
    @(posedge clock);
    radio_events.sync_and_address_match <= 1'b1;
    wait_mode(MODE_RX, n);
    repeat (40) @(posedge clock);
    `CHK(chip_mode, MODE_RX)
    pulse_end(5'h04);
    wait_mode(MODE_SLEEP, n);
    n = 0;
    repeat (40) begin
      @(posedge clock);
      #1 if (fifo_discard !== 1'b0) n++;
    end
    `CHK(n, 1)
    wr(ADDR_OP_MODE, 8'h24);
    rd(ADDR_OP_MODE, v);
    `CHK({v, listen_active}, 9'h008)
    // Action 00: stays receiving until enable cleared
    // Zero idle coefficient expires at once; idle unit code 11, 20 cycles here
    wr(ADDR_IDLE_COEFF, 8'h00);
    wr(ADDR_LISTEN_CFG, 8'he8);
    radio_events <= 5'h18;
    wr(ADDR_OP_MODE, 8'h44);
    wait_mode(MODE_RX, n);
    repeat (60) @(posedge clock);
    `CHK({chip_mode, listen_active}, {MODE_RX, 1'b1})
    wr(ADDR_OP_MODE, 8'h04);
    repeat (3) @(posedge clock);
    `CHK(listen_active, 1'b0)
    // Action 01: after timeout enter the mode field
    wr(ADDR_LISTEN_CFG, 8'hba);
    wr(ADDR_OP_MODE, 8'h48);
    wait_mode(MODE_RX, n);
    repeat (2) @(posedge clock);
    pulse_end(5'h02);
    wait_mode(3'h2, n);
    rd(ADDR_OP_MODE, v);
    `CHK({v, listen_active}, 9'h091)
    wr(ADDR_OP_MODE, 8'h04);
    repeat (3) @(posedge clock);
    `CHK(listen_active, 1'b0)
    final_report();
  end
endmodule : tb
